/* File: hdl/sdsd_map.vh */
// Constants for the card status record fetch and decoder
`ifndef SDSD_MAP_VH
`define SDSD_MAP_VH

// ==========================================================
// Commands on the SD command line
`define SDSD_CMD_APP_PREFIX   6'h37
`define SDSD_CMD_STATUS       6'h0d
`define SDSD_CMD_LEN          7'h30
`define SDSD_RESP_LEN         7'h30
`define SDSD_REC_BITS         10'h200
`define SDSD_CRC_BITS         5'h10

// ==========================================================
// Record field positions
`define SDSD_ERASE_OFS_HI     401
`define SDSD_ERASE_OFS_LO     400
`define SDSD_ERASE_TMO_HI     407
`define SDSD_ERASE_TMO_LO     402
`define SDSD_ERASE_CNT_HI     423
`define SDSD_ERASE_CNT_LO     408
`define SDSD_AU_HI            431
`define SDSD_AU_LO            428
`define SDSD_MOVE_HI          439
`define SDSD_MOVE_LO          432
`define SDSD_SPEED_HI         447
`define SDSD_SPEED_LO         440
`define SDSD_PROT_HI          479
`define SDSD_PROT_LO          448
`define SDSD_VARIANT_HI       495
`define SDSD_VARIANT_LO       480
`define SDSD_SECURE_BIT       509
`define SDSD_WIDTH_HI         511
`define SDSD_WIDTH_LO         510

// ==========================================================
// Card state and width codes
`define SDSD_STATE_TRAN       4'h4
`define SDSD_WIDTH_ONE        2'h0
`define SDSD_WIDTH_FOUR       2'h2
`define SDSD_VARIANT_RW       16'h0000
`define SDSD_VARIANT_RO       16'h0001

// ==========================================================
// APB register map
`define SDSD_REG_CTRL         6'h00
`define SDSD_REG_STAT         6'h04
`define SDSD_REG_ERASE        6'h08
`define SDSD_REG_PERF         6'h0c
`define SDSD_REG_PROT         6'h10
`define SDSD_REG_TYPE         6'h14
`define SDSD_REG_CSTAT        6'h18

// ==========================================================
// Timing
`define SDSD_LINK_DIV         8'h08
`define SDSD_RESP_WAIT        8'hc8
`define SDSD_DATA_WAIT        16'hffff

`endif

/* File: hdl/sdsd_top.v */
// Card status record fetcher and field decoder with APB registers
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "sdsd_map.vh"

module sdsd_top
(
   input  wire        CLK,
   input  wire        SYS_RST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [5:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   output reg         SD_CLK,
   output reg         SD_CMD_OUT,
   output reg         SD_CMD_OE,
   input  wire        SD_CMD_IN,
   input  wire        SD_DAT0_IN
);

   // ==========================================================
   // States
   localparam ST_IDLE  = 3'h0;
   localparam ST_SEND  = 3'h1;
   localparam ST_RESP  = 3'h2;
   localparam ST_WAITD = 3'h3;
   localparam ST_DATA  = 3'h4;
   localparam ST_CRC   = 3'h5;

   // ==========================================================
   // Pin synchronisers
   reg        cmd_s1, cmd_s2, dat_s1, dat_s2;
   always @(posedge CLK)
   begin
      cmd_s1 <= SD_CMD_IN;
      cmd_s2 <= cmd_s1;
      dat_s1 <= SD_DAT0_IN;
      dat_s2 <= dat_s1;
   end

   // ==========================================================
   // Card clock divider, enables on both edges
   reg  [7:0] div_cnt;
   reg        tick_fall, tick_rise;
   reg        run_clk;
   always @(posedge CLK)
   begin
      tick_fall <= 1'b0;
      tick_rise <= 1'b0;
      // Stop only in a low phase, so no short card clock pulse
      if (SYS_RST || (!run_clk && !SD_CLK))
      begin
         div_cnt <= 8'h00;
         SD_CLK  <= 1'b0;
      end
      else if (div_cnt == `SDSD_LINK_DIV - 8'h01)
      begin
         div_cnt   <= 8'h00;
         SD_CLK    <= ~SD_CLK;
         tick_fall <= SD_CLK;
         tick_rise <= ~SD_CLK;
      end
      else
         div_cnt <= div_cnt + 8'h01;
   end

   // ==========================================================
   // Command frame builder with CRC7
   function [6:0] crc7_step;
      input [6:0] crc;
      input       b;
      reg         fb;
      begin
         fb = crc[6] ^ b;
         crc7_step = {crc[5:0], fb} ^ {3'h0, fb, 3'h0};
      end
   endfunction
   function [47:0] build_cmd;
      input [5:0]  idx;
      input [31:0] arg;
      reg   [39:0] body;
      reg   [6:0]  c;
      integer      i;
      begin
         body = {2'b01, idx, arg};
         c = 7'h00;
         for (i = 39; i >= 0; i = i - 1)
            c = crc7_step(c, body[i]);
         build_cmd = {body, c, 1'b1};
      end
   endfunction

   // ==========================================================
   // Registers and state
   reg [2:0]   state;
   reg         second_cmd;
   reg [47:0]  cmd_sr;
   reg [6:0]   bit_cnt;
   reg [47:0]  resp_sr;
   reg [9:0]   rec_cnt;
   reg [4:0]   crc_cnt;
   reg [15:0]  wait_cnt;
   reg [511:0] rec_sr;
   reg [511:0] record;
   reg [15:0]  rca;
   reg [3:0]   card_state;
   reg [31:0]  card_status;
   reg         busy, done, err_state, err_tmo;
   wire apb_wr = PSEL && PENABLE && PWRITE && !PREADY;
   wire apb_rd = PSEL && PENABLE && !PWRITE && !PREADY;
   wire start_req = apb_wr && PADDR == `SDSD_REG_CTRL && PWDATA[0];
   // State written along with the start bit decides, not the old one
   wire in_tran = PWDATA[7:4] == `SDSD_STATE_TRAN;
   // ==========================================================
   // Decoded fields
   wire [1:0]  erase_offset =
      record[`SDSD_ERASE_OFS_HI:`SDSD_ERASE_OFS_LO];
   wire [5:0]  erase_tmo    =
      record[`SDSD_ERASE_TMO_HI:`SDSD_ERASE_TMO_LO];
   wire [15:0] erase_units  =
      record[`SDSD_ERASE_CNT_HI:`SDSD_ERASE_CNT_LO];
   wire [3:0]  alloc_unit_size_code = record[`SDSD_AU_HI:`SDSD_AU_LO];
   wire [7:0]  move_perf    = record[`SDSD_MOVE_HI:`SDSD_MOVE_LO];
   wire [7:0]  speed_class  = record[`SDSD_SPEED_HI:`SDSD_SPEED_LO];
   wire [31:0] protected_region_size =
      record[`SDSD_PROT_HI:`SDSD_PROT_LO];
   wire [15:0] card_variant = record[`SDSD_VARIANT_HI:`SDSD_VARIANT_LO];
   wire        secure_op_flag = record[`SDSD_SECURE_BIT];
   wire [1:0]  lane_width_code = record[`SDSD_WIDTH_HI:`SDSD_WIDTH_LO];
   // Standard card when high byte is zero
   wire std_card = card_variant[15:8] == 8'h00;
   wire var_ro   = card_variant == `SDSD_VARIANT_RO;
   wire var_rw   = card_variant == `SDSD_VARIANT_RW;
   wire w_one    = lane_width_code == `SDSD_WIDTH_ONE;
   wire w_four   = lane_width_code == `SDSD_WIDTH_FOUR;
   wire w_rsvd   = !w_one && !w_four;

   // ==========================================================
   // Fetch sequencer
   always @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         state       <= ST_IDLE;
         second_cmd  <= 1'b0;
         bit_cnt     <= 7'h00;
         record      <= 512'h0;
         run_clk     <= 1'b0;
         busy        <= 1'b0;
         done        <= 1'b0;
         err_state   <= 1'b0;
         err_tmo     <= 1'b0;
         card_status <= 32'h0;
         SD_CMD_OUT  <= 1'b1;
         SD_CMD_OE   <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (start_req)
               begin
                  done <= 1'b0;
                  // Refused outside transfer state
                  if (!in_tran)
                     err_state <= 1'b1;
                  else
                  begin
                     err_state  <= 1'b0;
                     err_tmo    <= 1'b0;
                     busy       <= 1'b1;
                     run_clk    <= 1'b1;
                     second_cmd <= 1'b0;
                     cmd_sr     <= build_cmd(`SDSD_CMD_APP_PREFIX,
                                             {PWDATA[31:16], 16'h0000});
                     bit_cnt    <= 7'h00;
                     state      <= ST_SEND;
                  end
               end
            end
            ST_SEND:
            begin
               // Drive on falling card clock edge
               if (tick_fall)
               begin
                  SD_CMD_OE  <= 1'b1;
                  SD_CMD_OUT <= cmd_sr[47];
                  cmd_sr     <= {cmd_sr[46:0], 1'b1};
                  bit_cnt    <= bit_cnt + 7'h01;
                  if (bit_cnt == `SDSD_CMD_LEN)
                  begin
                     SD_CMD_OE  <= 1'b0;
                     SD_CMD_OUT <= 1'b1;
                     bit_cnt    <= 7'h00;
                     wait_cnt   <= 16'h0000;
                     state      <= ST_RESP;
                  end
               end
            end
            ST_RESP:
            begin
               if (tick_rise)
               begin
                  if (bit_cnt == 7'h00 && cmd_s2)
                  begin
                     wait_cnt <= wait_cnt + 16'h0001;
                     if (wait_cnt[7:0] == `SDSD_RESP_WAIT)
                     begin
                        err_tmo <= 1'b1;
                        busy    <= 1'b0;
                        run_clk <= 1'b0;
                        state   <= ST_IDLE;
                     end
                  end
                  else
                  begin
                     resp_sr <= {resp_sr[46:0], cmd_s2};
                     bit_cnt <= bit_cnt + 7'h01;
                     if (bit_cnt == `SDSD_RESP_LEN - 7'h01)
                     begin
                        bit_cnt <= 7'h00;
                        // Response bits; class B/C flags taken as sent
                        card_status <= resp_sr[38:7];
                        if (!second_cmd)
                        begin
                           // Status command follows the prefix at once
                           second_cmd <= 1'b1;
                           cmd_sr <= build_cmd(`SDSD_CMD_STATUS, 32'h0);
                           state  <= ST_SEND;
                        end
                        else
                        begin
                           wait_cnt <= 16'h0000;
                           rec_cnt  <= 10'h000;
                           state    <= ST_WAITD;
                        end
                     end
                  end
               end
            end
            ST_WAITD:
            begin
               if (tick_rise)
               begin
                  wait_cnt <= wait_cnt + 16'h0001;
                  if (!dat_s2)
                     state <= ST_DATA;
                  else if (wait_cnt == `SDSD_DATA_WAIT)
                  begin
                     err_tmo <= 1'b1;
                     busy    <= 1'b0;
                     run_clk <= 1'b0;
                     state   <= ST_IDLE;
                  end
               end
            end
            ST_DATA:
            begin
               // Single 512-bit block, MSB first
               if (tick_rise)
               begin
                  rec_sr  <= {rec_sr[510:0], dat_s2};
                  rec_cnt <= rec_cnt + 10'h001;
                  if (rec_cnt == `SDSD_REC_BITS - 10'h001)
                  begin
                     crc_cnt <= 5'h00;
                     state   <= ST_CRC;
                  end
               end
            end
            ST_CRC:
            begin
               // CRC16 and end bit skipped, not checked
               if (tick_rise)
               begin
                  crc_cnt <= crc_cnt + 5'h01;
                  if (crc_cnt == `SDSD_CRC_BITS)
                  begin
                     record  <= rec_sr;
                     done    <= 1'b1;
                     busy    <= 1'b0;
                     run_clk <= 1'b0;
                     state   <= ST_IDLE;
                  end
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // APB slave, one wait state
   always @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         PRDATA     <= 32'h0;
         PREADY     <= 1'b0;
         PSLVERR    <= 1'b0;
         rca        <= 16'h0000;
         card_state <= 4'h0;
      end
      else
      begin
         PREADY  <= PSEL && PENABLE && !PREADY;
         PSLVERR <= 1'b0;
         if (apb_wr && PADDR == `SDSD_REG_CTRL)
         begin
            rca        <= PWDATA[31:16];
            card_state <= PWDATA[7:4];
         end
         if (apb_rd)
         begin
            case (PADDR)
               `SDSD_REG_CTRL:
                  PRDATA <= {rca, 8'h00, card_state, 4'h0};
               `SDSD_REG_STAT:
                  PRDATA <= {19'h0, lane_width_code, secure_op_flag,
                             w_rsvd, w_four, w_one, var_rw, var_ro,
                             std_card, err_tmo, err_state, done, busy};
               `SDSD_REG_ERASE:
                  PRDATA <= {8'h00, erase_units, erase_tmo,
                             erase_offset};
               `SDSD_REG_PERF:
                  PRDATA <= {12'h000, alloc_unit_size_code,
                             speed_class, move_perf};
               `SDSD_REG_PROT:
                  PRDATA <= protected_region_size;
               `SDSD_REG_TYPE:
                  PRDATA <= {16'h0000, card_variant};
               `SDSD_REG_CSTAT:
                  PRDATA <= card_status;
               default:
               begin
                  PRDATA  <= 32'h0;
                  PSLVERR <= 1'b1;
               end
            endcase
         end
         else if (apb_wr)
            PSLVERR <= PADDR != `SDSD_REG_CTRL;
      end
   end

endmodule // sdsd_top
`default_nettype wire

/* File: sim/sdsd_asserts.sv */
// Port-level checks for the status record fetcher
`timescale 1ns/1ns
`default_nettype none
module sdsd_asserts
(
   input wire logic        CLK,
   input wire logic        SYS_RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [5:0]  PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        SD_CLK,
   input wire logic        SD_CMD_OUT,
   input wire logic        SD_CMD_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // ==========================================================
   // Register bus
   a_ready_time: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready late");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready too long");
   a_ready_cause: assert property (!(PSEL && PENABLE) |=> !PREADY)
      else $error("ready without access");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_unmapped_err: assert property (PSEL && PENABLE && !PREADY && !PWRITE
      && PADDR > 6'h18 |=> PSLVERR && PRDATA == 32'h0)
      else $error("unmapped read not refused");
   // ==========================================================
   // Card link
   a_cmd_idle: assert property (!SD_CMD_OE |-> SD_CMD_OUT)
      else $error("command line not idle high");
   a_clk_high: assert property ($rose(SD_CLK) |-> ##8 $fell(SD_CLK))
      else $error("card clock high phase wrong");
   a_clk_low: assert property ($fell(SD_CLK) |=> $stable(SD_CLK)[*7])
      else $error("card clock low phase short");
   a_cmd_on_fall: assert property (SD_CMD_OE && $past(SD_CMD_OE)
      && $changed(SD_CMD_OUT) |-> $past(SD_CLK, 2) && !$past(SD_CLK))
      else $error("command bit changed off falling edge");
endmodule // sdsd_asserts
bind sdsd_top sdsd_asserts u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .SD_CLK(SD_CLK),
   .SD_CMD_OUT(SD_CMD_OUT), .SD_CMD_OE(SD_CMD_OE));
`default_nettype wire

/* File: sim/sdsd_card_model.sv */
// Behavioural memory card answering the status record fetch
`timescale 1ns/1ns
`default_nettype none
`include "sdsd_map.vh"
module sdsd_card_model
(
   input  wire logic         sd_clk,
   input  wire logic         cmd_line,
   input  wire logic [511:0] rec,
   input  wire logic [31:0]  card_status,
   input  wire logic         mute,
   input  wire logic [7:0]   data_delay,
   output var  logic         cmd_drv,
   output var  logic         cmd_oe,
   output var  logic         dat0
);
   logic [47:0]  frame;
   logic [529:0] blk;
   logic [5:0]   log_idx [0:15];
   logic [31:0]  log_arg [0:15];
   int           cmd_cnt;
   initial
   begin
      cmd_drv = 1'b1;
      cmd_oe = 1'b0;
      dat0 = 1'b1;
      cmd_cnt = 0;
      forever
      begin
         @(posedge sd_clk);
         if (cmd_line === 1'b0)
         begin
            for (int i = 46; i >= 0; i--)
            begin
               @(posedge sd_clk);
               frame[i] = cmd_line;
            end
            log_idx[cmd_cnt] = frame[45:40];
            log_arg[cmd_cnt] = frame[39:8];
            cmd_cnt++;
            if (!mute)
            begin
               repeat (2) @(negedge sd_clk);
               frame = {2'b00, frame[45:40], card_status, 8'h01};
               cmd_oe = 1'b1;
               for (int i = 47; i >= 0; i--)
               begin
                  cmd_drv = frame[i];
                  @(negedge sd_clk);
               end
               // Pull-up takes the line back to 1
               cmd_oe = 1'b0;
               cmd_drv = 1'b1;
               if (frame[45:40] == `SDSD_CMD_STATUS)
               begin
                  repeat (data_delay) @(negedge sd_clk);
                  blk = {1'b0, rec, 16'h0000, 1'b1};
                  for (int i = 529; i >= 0; i--)
                  begin
                     dat0 = blk[i];
                     @(negedge sd_clk);
                  end
               end
            end
         end
      end
   end
endmodule // sdsd_card_model
`default_nettype wire

/* File: sim/sdsd_tb_top.sv */
// Self-checking bench for the status record fetcher
`timescale 1ns/1ns
`default_nettype none
`include "sdsd_map.vh"
module sdsd_tb_top;
   logic         clk = 1'b0;
   logic         sys_rst = 1'b1;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [5:0]   paddr = 6'h00;
   logic [31:0]  pwdata = 32'h0;
   logic [31:0]  prdata, rdata;
   logic         pready, pslverr, rerr;
   logic         sd_clk, cmd_out, cmd_oe, cmd_line;
   logic         card_drv, card_oe, dat0;
   logic [511:0] rec = 512'h0;
   logic         mute = 1'b0;
   logic [7:0]   dly = 8'h03;
   int           fail_count = 0;
   int           total_checks = 0;
   int           b;
   always #5 clk = ~clk;
   // Tri-state style command line, host driver first, with card pull-up
   assign cmd_line = cmd_oe ? cmd_out : (card_oe ? card_drv : 1'b1);
   sdsd_top dut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SD_CLK(sd_clk),
      .SD_CMD_OUT(cmd_out), .SD_CMD_OE(cmd_oe), .SD_CMD_IN(cmd_line),
      .SD_DAT0_IN(dat0));
   sdsd_card_model card (.sd_clk(sd_clk), .cmd_line(cmd_line), .rec(rec),
      .card_status(32'h00000920), .mute(mute), .data_delay(dly),
      .cmd_drv(card_drv), .cmd_oe(card_oe), .dat0(dat0));
   task test_done();
      if (fail_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   // ==========================================================
   // Bus access
   task apb(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1 && ++n < 20);
      rdata = prdata;
      rerr = pslverr;
      chk("pready", {31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task fetch(input logic [15:0] rca, input logic [3:0] st);
      int n;
      n = 0;
      b = card.cmd_cnt;
      apb(1'b1, `SDSD_REG_CTRL, {rca, 8'h00, st, 4'h1});
      apb(1'b0, `SDSD_REG_CTRL, 32'h0);
      chk("ctrl", rdata, {rca, 8'h00, st, 4'h0});
      do
         apb(1'b0, `SDSD_REG_STAT, 32'h0);
      while (rdata[0] === 1'b1 && ++n < 5000);
   endtask
   task rec_test(input logic [1:0] w, input logic sec, input logic [15:0] vt,
      input logic [31:0] pa, input logic [7:0] spd, input logic [7:0] mv,
      input logic [3:0] au, input logic [15:0] ec, input logic [5:0] et,
      input logic [1:0] eo, input logic fill);
      rec = {512{fill}};
      rec[511:510] = w;
      rec[509] = sec;
      rec[495:480] = vt;
      rec[479:448] = pa;
      rec[447:440] = spd;
      rec[439:432] = mv;
      rec[431:428] = au;
      rec[423:408] = ec;
      rec[407:402] = et;
      rec[401:400] = eo;
      fetch(pa[31:16], `SDSD_STATE_TRAN);
      chk("stat", rdata, {19'h0, w, sec, w[0], w == 2'b10, w == 2'b00,
         vt == 16'h0, vt == 16'h1, vt[15:8] == 8'h0, 4'h2});
      chk("cmd_a", {26'h0, card.log_idx[b]},
         {26'h0, `SDSD_CMD_APP_PREFIX});
      chk("arg_a", card.log_arg[b], {pa[31:16], 16'h0});
      chk("cmd_b", {26'h0, card.log_idx[b+1]},
         {26'h0, `SDSD_CMD_STATUS});
      chk("arg_b", card.log_arg[b+1], 32'h0);
      apb(1'b0, `SDSD_REG_ERASE, 32'h0);
      chk("erase", rdata, {8'h0, ec, et, eo});
      apb(1'b0, `SDSD_REG_PERF, 32'h0);
      chk("perf", rdata, {12'h0, au, spd, mv});
      apb(1'b0, `SDSD_REG_PROT, 32'h0);
      chk("prot", rdata, pa);
      apb(1'b0, `SDSD_REG_TYPE, 32'h0);
      chk("type", rdata, {16'h0, vt});
      apb(1'b0, `SDSD_REG_CSTAT, 32'h0);
      chk("cstat", rdata, 32'h00000920);
   endtask
   initial
   begin
      #800000;
      fail_count++;
      test_done();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, `SDSD_REG_STAT, 32'h0);
      // Zeroed record decodes as one-bit width, standard read-write card
      chk("stat_rst", rdata, 32'h000000d0);
      apb(1'b0, 6'h1c, 32'h0);
      chk("unmap_err", {31'h0, rerr}, 32'h1);
      chk("unmap_data", rdata, 32'h0);
      apb(1'b1, `SDSD_REG_STAT, 32'hffffffff);
      chk("ro_err", {31'h0, rerr}, 32'h1);
      rec_test(2'b10, 1'b1, 16'h0001, 32'h89abcdef, 8'h03, 8'hfe, 4'h9,
         16'hffff, 6'h3f, 2'h3, 1'b1);
      dly <= 8'h28;
      rec_test(2'b00, 1'b0, 16'h0000, 32'h00010001, 8'h00, 8'h01, 4'h1,
         16'h0001, 6'h01, 2'h0, 1'b0);
      dly <= 8'h03;
      rec_test(2'b11, 1'b0, 16'h0100, 32'h76543210, 8'h02, 8'h80, 4'h6,
         16'h8421, 6'h2a, 2'h1, 1'b1);
      rec_test(2'b01, 1'b1, 16'h00a5, 32'h5a5a0f0f, 8'h01, 8'hff, 4'h0,
         16'h0000, 6'h00, 2'h2, 1'b0);
      fetch(16'h0001, 4'h3);
      chk("err_state", {29'h0, rdata[2:0]}, 32'h4);
      repeat (200) @(posedge clk);
      chk("no_cmd", card.cmd_cnt, b);
      mute <= 1'b1;
      fetch(16'h0002, `SDSD_STATE_TRAN);
      chk("tmo", {30'h0, rdata[3], rdata[0]}, 32'h2);
      chk("tmo_cmds", card.cmd_cnt, b + 1);
      test_done();
   end
endmodule // sdsd_tb_top
`default_nettype wire
